// ===== hdl/crf_core.sv
// Architectural registers, configuration load, timers and address unit
`timescale 1ns/10ps
module crf_core
  import crf_pkg::*;
#(
  parameter int FAST_DIVIDE = FAST_DIV,
  parameter int SLOW_DIVIDE = SLOW_DIV
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic io_req_i,
  input wire logic [15:0] io_cmd_i,
  input wire logic [15:0] io_wdata_i,
  output logic io_done_o,
  output logic io_fault_o,
  output logic [15:0] io_rdata_o,
  input wire logic priv_instr_i,
  output logic priv_exec_o,
  input wire logic bpt_i,
  input wire logic coproc_op_i,
  output logic coproc_exec_o,
  input wire logic resume_i,
  output logic console_mode_o,
  output logic cfg_rd_o,
  output logic [15:0] cfg_addr_o,
  input wire logic cfg_ack_i,
  input wire logic [4:0] bus_low_five_lines_i,
  output logic [4:0] system_configuration_o,
  output logic init_page_regs_o,
  output logic clear_protect_o,
  input wire logic [6:0] ext_irq_i,
  output logic [15:0] pending_interrupt_bits_o,
  output logic [15:0] interrupt_enable_mask_o,
  output logic [15:0] fault_flags_o,
  output logic [15:0] processor_status_word_o,
  input wire logic flags_we_i,
  input wire logic [3:0] flags_i,
  input wire logic gpr_we_i,
  input wire logic [3:0] gpr_waddr_i,
  input wire logic [15:0] gpr_wdata_i,
  input wire logic [3:0] fp_reg_i,
  output crf_float_t fp_single_o,
  output logic [39:0] fp_ext_mantissa_o,
  input wire logic ag_req_i,
  input wire crf_ag_req_t ag_i,
  input wire logic [15:0] instruction_counter_i,
  output logic ag_valid_o,
  output logic ag_indirect_o,
  output logic [15:0] ag_result_o
);
  typedef enum logic [1:0] {
    CF_IDLE = 2'b00,
    CF_READ = 2'b01,
    CF_INIT = 2'b10
  } crf_cfg_state_t;

  // Map a most-significant-first bit number to a vector index
  function automatic int msb_pos(input int n);
    msb_pos = 15 - n;
  endfunction : msb_pos

  // Index register read, register 0 means no indexing
  function automatic logic [15:0] index_of(input logic [3:0] sel,
                                           input logic [15:0] val);
    index_of = (sel == 4'h0) ? WORD_RESET : val;
  endfunction : index_of

  logic [15:0] general_purpose_set [16];
  logic [15:0] pending_interrupt_bits;
  logic [15:0] interrupt_enable_mask;
  logic [15:0] fault_flags;
  crf_sw_t processor_status_word;
  logic [4:0] system_configuration;
  crf_cfg_state_t cfg_state;
  logic cfg_pending;
  logic io_ok;
  logic io_priv_fail;
  logic as_fault;
  crf_sw_t next_sw;
  logic [15:0] fast_count;
  logic [15:0] slow_count;
  logic fast_wrap;
  logic slow_wrap;
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic [6:0] sync3;
  logic [6:0] irq_lvl;
  logic [6:0] irq_lvl_d;
  logic [6:0] irq_hit;
  logic [15:0] irq_set;
  logic [15:0] fault_set;
  logic [15:0] rx_val;
  logic [15:0] base_val;
  logic [15:0] next_ag;

  // Privilege check shared by I/O commands and other privileged work
  assign io_ok = (processor_status_word.access_key == 4'h0);
  assign io_priv_fail = io_req_i && !io_ok;
  assign priv_exec_o = priv_instr_i && io_ok;
  assign coproc_exec_o = coproc_op_i &&
    system_configuration[CFG_COPROC_POS];
  assign system_configuration_o = system_configuration;
  assign pending_interrupt_bits_o = pending_interrupt_bits;
  assign interrupt_enable_mask_o = interrupt_enable_mask;
  assign fault_flags_o = fault_flags;
  assign processor_status_word_o = processor_status_word;
  assign cfg_rd_o = (cfg_state == CF_READ);
  assign cfg_addr_o = CFG_IO_ADDR;

  // Configuration read sequence, started by reset and by breakpoint
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cfg_state <= CF_IDLE;
      cfg_pending <= 1'b1;
      system_configuration <= CFG_RESET;
      init_page_regs_o <= 1'b0;
      clear_protect_o <= 1'b0;
    end else begin
      init_page_regs_o <= 1'b0;
      clear_protect_o <= 1'b0;
      if (bpt_i) begin
        cfg_pending <= 1'b1;
      end
      case (cfg_state)
        CF_IDLE: begin
          if (cfg_pending || bpt_i) begin
            cfg_state <= CF_READ;
          end
        end
        CF_READ: begin
          // Only this path and reset write the configuration; software cannot
          if (cfg_ack_i) begin
            system_configuration <= bus_low_five_lines_i;
            cfg_state <= CF_INIT;
            if (!bpt_i) begin
              cfg_pending <= 1'b0;
            end
          end
        end
        CF_INIT: begin
          // Start-up initialisation after every load, reset-time or breakpoint
          cfg_state <= CF_IDLE;
          init_page_regs_o <= system_configuration[CFG_MMU_POS];
          clear_protect_o <= system_configuration[CFG_BPU_POS];
        end
        default: begin
          cfg_state <= CF_IDLE;
        end
      endcase
    end
  end

  // Console mode entered on breakpoint when a console is fitted
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      console_mode_o <= 1'b0;
    end else if (bpt_i && system_configuration[CFG_CONSOLE_POS]) begin
      console_mode_o <= 1'b1;
    end else if (resume_i) begin
      console_mode_o <= 1'b0;
    end
  end

  // Two interval timers; console mode freezes both
  crf_interval_timer #(
    .DIV(FAST_DIVIDE)
  ) u_fast (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .load_i(io_req_i && io_ok && io_cmd_i == CMD_LOAD_FAST),
    .load_val_i(io_wdata_i),
    .start_i(io_req_i && io_ok && io_cmd_i == CMD_START_FAST),
    .halt_i(io_req_i && io_ok && io_cmd_i == CMD_HALT_FAST),
    .freeze_i(console_mode_o),
    .count_o(fast_count),
    .wrap_o(fast_wrap),
    .running_o()
  );

  crf_interval_timer #(
    .DIV(SLOW_DIVIDE)
  ) u_slow (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .load_i(io_req_i && io_ok && io_cmd_i == CMD_LOAD_SLOW),
    .load_val_i(io_wdata_i),
    .start_i(io_req_i && io_ok && io_cmd_i == CMD_START_SLOW),
    .halt_i(io_req_i && io_ok && io_cmd_i == CMD_HALT_SLOW),
    .freeze_i(console_mode_o),
    .count_o(slow_count),
    .wrap_o(slow_wrap),
    .running_o()
  );

  // Three-stage pin synchroniser; only the last two feed the filter
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      sync1 <= 7'h00;
      sync2 <= 7'h00;
      sync3 <= 7'h00;
      irq_lvl <= 7'h00;
      irq_lvl_d <= 7'h00;
    end else begin
      sync1 <= ext_irq_i;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < 7; i++) begin
        if (sync2[i] == sync3[i]) begin
          irq_lvl[i] <= sync3[i];
        end
      end
      irq_lvl_d <= irq_lvl;
    end
  end

  // Edge or sampled level, chosen by the interrupt mode bit
  assign irq_hit = system_configuration[CFG_IRQ_EDGE_POS] ?
    (irq_lvl & ~irq_lvl_d) : irq_lvl;

  // Pin 0 power down, pins 1-6 user 0 to 5
  always_comb begin
    irq_set = WORD_RESET;
    irq_set[msb_pos(PIR_POWER_POS)] = irq_hit[0];
    irq_set[msb_pos(2)] = irq_hit[1];
    irq_set[msb_pos(8)] = irq_hit[2];
    irq_set[msb_pos(10)] = irq_hit[3];
    irq_set[msb_pos(11)] = irq_hit[4];
    irq_set[msb_pos(13)] = irq_hit[5];
    irq_set[msb_pos(15)] = irq_hit[6];
    irq_set[msb_pos(PIR_FAST_POS)] = fast_wrap;
    irq_set[msb_pos(PIR_SLOW_POS)] = slow_wrap;
  end

  // Pending register: hardware sets win over software clears
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pending_interrupt_bits <= WORD_RESET;
    end else begin
      if (io_req_i && io_ok && io_cmd_i == CMD_CLR_PEND) begin
        pending_interrupt_bits <= irq_set;
      end else if (io_req_i && io_ok && io_cmd_i == CMD_RST_PEND) begin
        pending_interrupt_bits <= (pending_interrupt_bits & ~io_wdata_i) |
                                  irq_set;
      end else if (io_req_i && io_ok && io_cmd_i == CMD_SET_PEND) begin
        pending_interrupt_bits <= pending_interrupt_bits | io_wdata_i |
                                  irq_set;
      end else begin
        pending_interrupt_bits <= pending_interrupt_bits | irq_set;
      end
    end
  end

  // Mask register, written by command
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      interrupt_enable_mask <= WORD_RESET;
    end else if (io_req_i && io_ok && io_cmd_i == CMD_SET_MASK) begin
      interrupt_enable_mask <= io_wdata_i;
    end
  end

  // Address state may only leave zero when memory management exists
  always_comb begin
    next_sw = processor_status_word;
    as_fault = 1'b0;
    if (io_req_i && io_ok && io_cmd_i == CMD_WRITE_SW) begin
      next_sw = crf_sw_t'(io_wdata_i);
      if (!system_configuration[CFG_MMU_POS] &&
          processor_status_word.page_group_select == 4'h0 &&
          next_sw.page_group_select != 4'h0) begin
        next_sw.page_group_select = 4'h0;
        as_fault = 1'b1;
      end
    end
    if (flags_we_i) begin
      {next_sw.carry, next_sw.positive, next_sw.zero,
       next_sw.negative} = flags_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      processor_status_word <= crf_sw_t'(WORD_RESET);
    end else begin
      processor_status_word <= next_sw;
    end
  end

  // Fault flags: a new fault survives a read-and-clear in the same cycle
  always_comb begin
    fault_set = WORD_RESET;
    fault_set[msb_pos(FT_PRIV_POS)] = io_priv_fail ||
      (priv_instr_i && !io_ok);
    fault_set[msb_pos(FT_ADDR_STATE_POS)] = as_fault;
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      fault_flags <= WORD_RESET;
    end else if (io_req_i && io_ok && io_cmd_i == CMD_READ_FAULT) begin
      fault_flags <= fault_set;
    end else begin
      fault_flags <= fault_flags | fault_set;
    end
  end

  // Command completion and read data, one cycle after the request
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      io_done_o <= 1'b0;
      io_fault_o <= 1'b0;
      io_rdata_o <= WORD_RESET;
    end else begin
      io_done_o <= io_req_i;
      io_fault_o <= io_priv_fail;
      if (io_req_i && io_ok) begin
        case (io_cmd_i)
          CMD_READ_FAST: io_rdata_o <= fast_count;
          CMD_READ_SLOW: io_rdata_o <= slow_count;
          CMD_READ_MASK: io_rdata_o <= interrupt_enable_mask;
          CMD_READ_PEND: io_rdata_o <= pending_interrupt_bits;
          CMD_READ_FAULT: io_rdata_o <= fault_flags;
          CMD_READ_SW: io_rdata_o <= processor_status_word;
          default: io_rdata_o <= WORD_RESET;
        endcase
      end else begin
        io_rdata_o <= WORD_RESET;
      end
    end
  end

  // General registers, not reset
  always_ff @(posedge sys_clk_i) begin
    if (gpr_we_i) begin
      general_purpose_set[gpr_waddr_i] <= gpr_wdata_i;
    end
  end

  // Float view of a register group, word 0 on top
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      fp_single_o <= '0;
      fp_ext_mantissa_o <= 40'h0000000000;
    end else begin
      fp_single_o <= {general_purpose_set[fp_reg_i],
                      general_purpose_set[fp_reg_i + 4'h1]};
      fp_ext_mantissa_o <= {general_purpose_set[fp_reg_i],
        general_purpose_set[fp_reg_i + 4'h1][15:8],
        general_purpose_set[fp_reg_i + 4'h2]};
    end
  end

  // Operand address or value for each addressing mode
  assign rx_val = index_of(ag_i.reg_sel, general_purpose_set[ag_i.reg_sel]);
  assign base_val = general_purpose_set[{2'b11, ag_i.base_sel}];

  always_comb begin
    next_ag = ag_i.word2;
    case (ag_i.mode)
      AM_REG: next_ag = general_purpose_set[ag_i.reg_sel];
      AM_DIRECT: next_ag = ag_i.word2;
      AM_DIRECT_INDEXED: next_ag = ag_i.word2 + rx_val;
      AM_INDIRECT: next_ag = ag_i.word2;
      AM_INDIRECT_PREINDEXED: next_ag = ag_i.word2 + rx_val;
      AM_IMMEDIATE: next_ag = ag_i.word2;
      AM_IMMEDIATE_INDEXED: next_ag = ag_i.word2 + rx_val;
      AM_SHORT_POSITIVE: next_ag = {12'h000, ag_i.short_val} +
        16'h0001;
      AM_SHORT_NEGATIVE: next_ag = 16'h0000 -
        ({12'h000, ag_i.short_val} + 16'h0001);
      AM_COUNTER_RELATIVE: next_ag = instruction_counter_i - 16'h0001 +
        {{8{ag_i.disp[7]}}, ag_i.disp};
      AM_BASE_RELATIVE: next_ag = base_val +
        {8'h00, ag_i.disp};
      AM_BASE_INDEXED: next_ag = base_val + rx_val;
      AM_SPECIAL: next_ag = ag_i.word2;
      default: next_ag = ag_i.word2;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ag_valid_o <= 1'b0;
      ag_indirect_o <= 1'b0;
      ag_result_o <= WORD_RESET;
    end else begin
      ag_valid_o <= ag_req_i;
      ag_indirect_o <= ag_req_i && (ag_i.mode == AM_INDIRECT ||
        ag_i.mode == AM_INDIRECT_PREINDEXED);
      if (ag_req_i) begin
        ag_result_o <= next_ag;
      end
    end
  end
endmodule : crf_core

// ===== hdl/crf_pkg.sv
// Shared constants and types for the register and addressing block
package crf_pkg;
  // Clock and timer tick periods
  localparam int CLK_PERIOD_NS = 50;
  localparam int FAST_TICK_NS = 10000;
  localparam int SLOW_TICK_NS = 100000;
  localparam int FAST_DIV = FAST_TICK_NS / CLK_PERIOD_NS;
  localparam int SLOW_DIV = SLOW_TICK_NS / CLK_PERIOD_NS;
  // I/O addresses and commands
  localparam logic [15:0] CFG_IO_ADDR = 16'h8410;
  localparam logic [15:0] CMD_START_FAST = 16'h4008;
  localparam logic [15:0] CMD_HALT_FAST = 16'h4009;
  localparam logic [15:0] CMD_LOAD_FAST = 16'h400a;
  localparam logic [15:0] CMD_READ_FAST = 16'hc00a;
  localparam logic [15:0] CMD_START_SLOW = 16'h400c;
  localparam logic [15:0] CMD_HALT_SLOW = 16'h400d;
  localparam logic [15:0] CMD_LOAD_SLOW = 16'h400e;
  localparam logic [15:0] CMD_READ_SLOW = 16'hc00e;
  localparam logic [15:0] CMD_SET_MASK = 16'h2000;
  localparam logic [15:0] CMD_CLR_PEND = 16'h2001;
  localparam logic [15:0] CMD_RST_PEND = 16'h2004;
  localparam logic [15:0] CMD_SET_PEND = 16'h2005;
  localparam logic [15:0] CMD_READ_MASK = 16'ha000;
  localparam logic [15:0] CMD_READ_PEND = 16'ha004;
  localparam logic [15:0] CMD_READ_FAULT = 16'ha00f;
  localparam logic [15:0] CMD_WRITE_SW = 16'h200e;
  localparam logic [15:0] CMD_READ_SW = 16'ha00e;
  // Bit positions, numbered with 0 as the most significant bit
  localparam int FT_PRIV_POS = 10;
  localparam int FT_ADDR_STATE_POS = 11;
  localparam int PIR_POWER_POS = 0;
  localparam int PIR_FAST_POS = 7;
  localparam int PIR_SLOW_POS = 9;
  // Configuration bit positions on the low bus lines
  localparam int CFG_MMU_POS = 0;
  localparam int CFG_BPU_POS = 1;
  localparam int CFG_CONSOLE_POS = 2;
  localparam int CFG_COPROC_POS = 3;
  localparam int CFG_IRQ_EDGE_POS = 4;
  // Reset values
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [4:0] CFG_RESET = 5'h00;

  typedef struct packed {
    logic carry;
    logic positive;
    logic zero;
    logic negative;
    logic [3:0] spare;
    logic [3:0] access_key;
    logic [3:0] page_group_select;
  } crf_sw_t;

  typedef struct packed {
    logic [23:0] mantissa;
    logic [7:0] exponent;
  } crf_float_t;

  typedef enum logic [3:0] {
    AM_REG = 4'h0,
    AM_DIRECT = 4'h1,
    AM_DIRECT_INDEXED = 4'h2,
    AM_INDIRECT = 4'h3,
    AM_INDIRECT_PREINDEXED = 4'h4,
    AM_IMMEDIATE = 4'h5,
    AM_IMMEDIATE_INDEXED = 4'h6,
    AM_SHORT_POSITIVE = 4'h7,
    AM_SHORT_NEGATIVE = 4'h8,
    AM_COUNTER_RELATIVE = 4'h9,
    AM_BASE_RELATIVE = 4'ha,
    AM_BASE_INDEXED = 4'hb,
    AM_SPECIAL = 4'hc
  } crf_mode_t;

  typedef struct packed {
    crf_mode_t mode;
    logic [3:0] reg_sel;
    logic [1:0] base_sel;
    logic [15:0] word2;
    logic [7:0] disp;
    logic [3:0] short_val;
  } crf_ag_req_t;
endpackage : crf_pkg

// ===== hdl/crf_interval_timer.sv
// Free-running 16-bit up-counting interval timer with prescaler
`timescale 1ns/10ps
module crf_interval_timer #(
  parameter int DIV = 200
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic load_i,
  input wire logic [15:0] load_val_i,
  input wire logic start_i,
  input wire logic halt_i,
  input wire logic freeze_i,
  output logic [15:0] count_o,
  output logic wrap_o,
  output logic running_o
);
  localparam int PW = $clog2(DIV);
  logic [PW-1:0] presc;
  logic tick;

  assign tick = (presc == PW'(DIV - 1));

  // Run state: halted after reset until started
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      running_o <= 1'b0;
    end else if (halt_i) begin
      running_o <= 1'b0;
    end else if (start_i) begin
      running_o <= 1'b1;
    end
  end

  // Prescaler only advances while running and not frozen
  always_ff @(posedge sys_clk_i) begin
    if (srst_i || load_i || !running_o || freeze_i) begin
      presc <= '0;
    end else if (tick) begin
      presc <= '0;
    end else begin
      presc <= presc + PW'(1);
    end
  end

  // Count is not cleared by reset; software loads it first
  always_ff @(posedge sys_clk_i) begin
    if (load_i) begin
      count_o <= load_val_i;
    end else if (running_o && !freeze_i && tick) begin
      count_o <= count_o + 16'h0001;
    end
  end

  // One-cycle pulse on wrap from all ones to zero
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      wrap_o <= 1'b0;
    end else begin
      wrap_o <= running_o && !freeze_i && tick && !load_i &&
                (count_o == 16'hffff);
    end
  end
endmodule : crf_interval_timer

// ===== test/crf_cfg_responder.sv
// Far-side logic that answers the configuration read
`timescale 1ns/10ps
module crf_cfg_responder
  import crf_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic cfg_rd_i,
  input wire logic [15:0] cfg_addr_i,
  input wire logic [4:0] cfg_val_i,
  input wire logic [3:0] delay_i,
  output logic cfg_ack_o = 1'b0,
  output logic [4:0] lines_o = 5'h0a
);
  logic [3:0] wait_q = 4'h0;

  // Lines toggle outside the data phase so stale bits never look valid
  always @(negedge sys_clk_i) begin
    if (cfg_rd_i && cfg_addr_i == CFG_IO_ADDR && !cfg_ack_o
        && wait_q == delay_i) begin
      cfg_ack_o <= 1'b1;
      lines_o <= cfg_val_i;
      wait_q <= 4'h0;
    end else begin
      cfg_ack_o <= 1'b0;
      lines_o <= ~lines_o;
      wait_q <= (cfg_rd_i && !cfg_ack_o) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : crf_cfg_responder

// ===== test/crf_core_asserts.sv
// Port-level checks of the register and addressing core
`timescale 1ns/10ps
module crf_core_asserts
  import crf_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic io_req_i,
  input wire logic io_fault_o,
  input wire logic [15:0] fault_flags_o,
  input wire logic [15:0] processor_status_word_o,
  input wire logic priv_instr_i,
  input wire logic priv_exec_o,
  input wire logic bpt_i,
  input wire logic console_mode_o,
  input wire logic coproc_op_i,
  input wire logic coproc_exec_o,
  input wire logic cfg_rd_o,
  input wire logic cfg_ack_i,
  input wire logic [4:0] bus_low_five_lines_i,
  input wire logic [4:0] system_configuration_o,
  input wire logic init_page_regs_o,
  input wire logic clear_protect_o,
  input wire logic ag_req_i,
  input wire logic ag_valid_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  // Data phase of the read, then the cycle the load lands
  sequence s_take;
    cfg_rd_o && cfg_ack_i;
  endsequence
  sequence s_load;
    s_take ##1 1'b1;
  endsequence

  AST_PRIV_FAULT: assert property (
    io_req_i && processor_status_word_o[7:4] != 4'h0
    |=> io_fault_o && fault_flags_o[15 - FT_PRIV_POS])
    else $error("privilege fault missing");
  AST_PRIV_EXEC: assert property (
    priv_instr_i |-> priv_exec_o == (processor_status_word_o[7:4] == 4'h0))
    else $error("privileged op gating wrong");
  AST_CFG_LOAD: assert property (
    s_take |=> system_configuration_o == $past(bus_low_five_lines_i))
    else $error("configuration not loaded");
  AST_CFG_HOLD: assert property (
    !(cfg_rd_o && cfg_ack_i) |=> $stable(system_configuration_o))
    else $error("configuration changed without read");
  AST_INIT_PULSE: assert property (
    s_load |=> init_page_regs_o == $past(bus_low_five_lines_i[CFG_MMU_POS], 2)
    && clear_protect_o == $past(bus_low_five_lines_i[CFG_BPU_POS], 2))
    else $error("init pulses wrong");
  AST_COPROC: assert property (
    coproc_exec_o == (coproc_op_i && system_configuration_o[CFG_COPROC_POS]))
    else $error("coprocessor gating wrong");
  AST_BPT_RELOAD: assert property (
    bpt_i |-> ##[1:3] cfg_rd_o)
    else $error("breakpoint did not reload");
  AST_CONSOLE: assert property (
    bpt_i && system_configuration_o[CFG_CONSOLE_POS]
    |-> ##[1:3] console_mode_o)
    else $error("console mode not entered");
  AST_AG_VALID: assert property (
    ag_req_i |=> ag_valid_o)
    else $error("address result late");
endmodule : crf_core_asserts

bind crf_core crf_core_asserts u_chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
  .io_req_i(io_req_i), .io_fault_o(io_fault_o), .fault_flags_o(fault_flags_o),
  .processor_status_word_o(processor_status_word_o),
  .priv_instr_i(priv_instr_i), .priv_exec_o(priv_exec_o), .bpt_i(bpt_i),
  .console_mode_o(console_mode_o), .coproc_op_i(coproc_op_i),
  .coproc_exec_o(coproc_exec_o), .cfg_rd_o(cfg_rd_o), .cfg_ack_i(cfg_ack_i),
  .bus_low_five_lines_i(bus_low_five_lines_i),
  .system_configuration_o(system_configuration_o),
  .init_page_regs_o(init_page_regs_o), .clear_protect_o(clear_protect_o),
  .ag_req_i(ag_req_i), .ag_valid_o(ag_valid_o));

// ===== test/cpu_registers_addressing_tb.sv
// Self-checking bench of the register and addressing core
`timescale 1ns/10ps
module cpu_registers_addressing_tb;
  import crf_pkg::*;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic req = 1'b0, breakpoint_instruction = 1'b0, cop = 1'b0, resume = 1'b0, priv = 1'b0;
  logic fl_we = 1'b0, g_we = 1'b0, ag_req = 1'b0, ack, rd_o, done, flt, fltq;
  logic pex, cex, con, ipr, clp, agv, agi, oc;
  logic [6:0] irq = 7'h00;
  logic [3:0] fl = 4'h0, ga = 4'h0, fpr = 4'h0, dly = 4'h0;
  logic [4:0] cfg_v = 5'h0, lines, cfg_o;
  logic [15:0] cmd = 16'h0, wd = 16'h0, gd = 16'h0, ic = 16'h0, rdq, rd, e;
  logic [15:0] pend, ft, sw, agr, cfa;
  logic [15:0] r [16];
  logic [39:0] fpx;
  crf_float_t fps;
  crf_ag_req_t ag = '0;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;

  // Short timer divides keep the wrap scenarios brief
  crf_core #(.FAST_DIVIDE(4), .SLOW_DIVIDE(8)) dut (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .io_req_i(req), .io_cmd_i(cmd),
    .io_wdata_i(wd), .io_done_o(done), .io_fault_o(flt), .io_rdata_o(rdq),
    .priv_instr_i(priv), .priv_exec_o(pex), .bpt_i(breakpoint_instruction), .coproc_op_i(cop),
    .coproc_exec_o(cex), .resume_i(resume), .console_mode_o(con),
    .cfg_rd_o(rd_o), .cfg_addr_o(cfa), .cfg_ack_i(ack),
    .bus_low_five_lines_i(lines), .system_configuration_o(cfg_o),
    .init_page_regs_o(ipr), .clear_protect_o(clp), .ext_irq_i(irq),
    .pending_interrupt_bits_o(pend), .interrupt_enable_mask_o(),
    .fault_flags_o(ft), .processor_status_word_o(sw), .flags_we_i(fl_we),
    .flags_i(fl), .gpr_we_i(g_we), .gpr_waddr_i(ga), .gpr_wdata_i(gd),
    .fp_reg_i(fpr), .fp_single_o(fps), .fp_ext_mantissa_o(fpx),
    .ag_req_i(ag_req), .ag_i(ag), .instruction_counter_i(ic),
    .ag_valid_o(agv), .ag_indirect_o(agi), .ag_result_o(agr));
  crf_cfg_responder u_far (.sys_clk_i(sys_clk_i), .cfg_rd_i(rd_o),
    .cfg_addr_i(cfa), .cfg_val_i(cfg_v), .delay_i(dly), .cfg_ack_o(ack),
    .lines_o(lines));

  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task automatic nx();
    @(negedge sys_clk_i);
  endtask : nx
  task automatic chk(string n, logic [39:0] s, logic [39:0] x);
    n_tests++;
    if (s !== x) begin
      failures++;
      $display("CHECK FAILED %s exp %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop
  // One command; answer is sampled in its single cycle
  task automatic io(logic [15:0] c, logic [15:0] w);
    req = 1'b1;
    cmd = c;
    wd = w;
    nx();
    rd = rdq;
    fltq = flt;
    chk("done", done, 1'b1);
    req = 1'b0;
    nx();
  endtask : io
  task automatic wait_cfg();
    for (int i = 0; i < 30 && (i < 3 || rd_o !== 1'b0); i++) nx();
    nx();
  endtask : wait_cfg
  task automatic ops(logic p);
    priv = 1'b1;
    cop = 1'b1;
    #1;
    chk("pex", pex, p);
    chk("cex", cex, cfg_v[CFG_COPROC_POS]);
    nx();
    priv = 1'b0;
    cop = 1'b0;
    nx();
  endtask : ops
  // Operand address model; index select zero means no index
  function automatic logic [15:0] agx(crf_ag_req_t a, logic [15:0] c);
    logic [15:0] x;
    logic [15:0] b;
    x = (a.reg_sel == 4'h0) ? 16'h0 : r[a.reg_sel];
    b = r[12 + a.base_sel];
    case (a.mode)
      AM_REG: return r[a.reg_sel];
      AM_DIRECT, AM_INDIRECT, AM_IMMEDIATE, AM_SPECIAL: return a.word2;
      AM_SHORT_POSITIVE: return 16'(a.short_val) + 16'h1;
      AM_SHORT_NEGATIVE: return 16'h0 - 16'(a.short_val) - 16'h1;
      AM_COUNTER_RELATIVE: return c - 16'h1 + {{8{a.disp[7]}}, a.disp};
      AM_BASE_RELATIVE: return b + 16'(a.disp);
      AM_BASE_INDEXED: return b + x;
      default: return a.word2 + x;
    endcase
  endfunction : agx

  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(32'h396f));
    cfg_v = 5'($urandom) & 5'h1e | 5'h04;
    dly = 4'($urandom_range(0, 6));
    repeat (10) nx();
    srst_i = 1'b0;
    wait_cfg();
    chk("cfg", cfg_o, cfg_v);
    ops(1'b1);
    e = 16'($urandom) & 16'hff0f | 16'h0001;
    io(CMD_WRITE_SW, e);
    io(CMD_READ_SW, 16'h0);
    chk("sw", rd, e & 16'hfff0);
    chk("asf", ft[15 - FT_ADDR_STATE_POS], 1'b1);
    io(CMD_SET_MASK, e);
    io(CMD_READ_MASK, 16'h0);
    chk("mk", rd, e);
    fl = 4'($urandom);
    fl_we = 1'b1;
    nx();
    fl_we = 1'b0;
    nx();
    chk("flg", sw[15:12], fl);
    g_we = 1'b1;
    for (int i = 0; i < 16; i++) begin
      ga = 4'(i);
      gd = 16'($urandom);
      r[i] = gd;
      nx();
    end
    g_we = 1'b0;
    fpr = 4'($urandom_range(0, 13));
    nx();
    chk("fps", fps, {r[fpr], r[fpr + 1]});
    chk("fpx", fpx, {r[fpr], r[fpr + 1][15:8], r[fpr + 2]});
    // Back-to-back address requests over all thirteen addressing modes
    ag_req = 1'b1;
    for (int i = 0; i < 60; i++) begin
      ag = crf_ag_req_t'(38'({$urandom, $urandom}));
      ag.mode = crf_mode_t'(4'($urandom_range(0, 12)));
      ic = 16'($urandom);
      nx();
      chk("agr", agr, agx(ag, ic));
      chk("agv", agv, 1'b1);
      chk("agi", agi, ag.mode inside {AM_INDIRECT,
          AM_INDIRECT_PREINDEXED});
    end
    ag_req = 1'b0;
    for (int k = 0; k < 2; k++) begin
      io(k ? CMD_LOAD_SLOW : CMD_LOAD_FAST, 16'hfffe);
      io(k ? CMD_START_SLOW : CMD_START_FAST, 16'h0);
      repeat (k ? 40 : 20) nx();
      chk("wrap", pend[k ? 15 - PIR_SLOW_POS : 15 - PIR_FAST_POS],
          1'b1);
      io(k ? CMD_HALT_SLOW : CMD_HALT_FAST, 16'h0);
      io(k ? CMD_READ_SLOW : CMD_READ_FAST, 16'h0);
      e = rd;
      chk("run", e < 16'h8, 1'b1);
      repeat (20) nx();
      io(k ? CMD_READ_SLOW : CMD_READ_FAST, 16'h0);
      chk("halt", rd, e);
    end
    // Held user 0 pin: a clear only sticks in edge mode
    irq = 7'h02;
    repeat (8) nx();
    chk("irq", pend[15 - 2], 1'b1);
    io(CMD_CLR_PEND, 16'h0);
    chk("lvl", pend[15 - 2], !cfg_o[CFG_IRQ_EDGE_POS]);
    irq = 7'h00;
    // Fast timer left running so console freeze can be seen
    io(CMD_START_FAST, 16'h0);
    // Breakpoint reloads; console entry follows the earlier setting
    for (int k = 0; k < 2; k++) begin
      oc = cfg_v[CFG_CONSOLE_POS];
      cfg_v = 5'($urandom) & 5'h1e;
      dly = 4'($urandom_range(0, 6));
      breakpoint_instruction = 1'b1;
      nx();
      breakpoint_instruction = 1'b0;
      wait_cfg();
      chk("con", con, oc);
      chk("cfg", cfg_o, cfg_v);
      io(CMD_READ_FAST, 16'h0);
      e = rd;
      repeat (8) nx();
      io(CMD_READ_FAST, 16'h0);
      chk("frz", rd == e, oc);
      resume = 1'b1;
      nx();
      resume = 1'b0;
      nx();
      chk("res", con, 1'b0);
    end
    io(CMD_WRITE_SW, 16'h0010);
    ops(1'b0);
    io(CMD_READ_SW, 16'h0);
    chk("pf", fltq, 1'b1);
    chk("pft", ft[15 - FT_PRIV_POS], 1'b1);
    srst_i = 1'b1;
    repeat (3) nx();
    srst_i = 1'b0;
    wait_cfg();
    chk("rst", sw, 16'h0);
    ops(1'b1);
    report_and_stop();
  end
endmodule : cpu_registers_addressing_tb
